// file: ffrs_pkg.sv
/*
  Package for the fault flag and output range select register bank:
  register offsets, field positions, reset values, range limits and the
  packed carriers that the top level and the range selector share.
  Assumes an 8-bit register pointer reached through a two-wire serial port.
*/
package ffrs_pkg;

  // register offsets
  localparam logic [7:0] FFRS_OFS_FLAGS      = 8'h18;
  localparam logic [7:0] FFRS_OFS_RANGE_HIGH = 8'h1C;
  localparam logic [7:0] FFRS_OFS_RANGE_LOW  = 8'h1D;

  // field positions in the fault register
  localparam int FFRS_BIT_OVERCURRENT   = 7;
  localparam int FFRS_BIT_SHORT_CIRCUIT = 4;
  localparam int FFRS_BIT_UNDERVOLTAGE  = 1;

  // values after reset
  localparam logic [2:0] FFRS_FLAGS_RESET      = 3'h0;
  localparam logic [1:0] FFRS_RANGE_HIGH_RESET = 2'h2;
  localparam logic [1:0] FFRS_RANGE_LOW_RESET  = 2'h1;

  // serial frame counts
  localparam logic [3:0] FFRS_BITS_PER_BYTE = 4'h8;

  // range limits in microvolts, codes 00 to 11
  localparam logic [22:0] FFRS_RANGE0_MIN_UV = 23'd303125;
  localparam logic [22:0] FFRS_RANGE0_MAX_UV = 23'd700000;
  localparam logic [22:0] FFRS_RANGE1_MIN_UV = 23'd606250;
  localparam logic [22:0] FFRS_RANGE1_MAX_UV = 23'd1400000;
  localparam logic [22:0] FFRS_RANGE2_MIN_UV = 23'd1212500;
  localparam logic [22:0] FFRS_RANGE2_MAX_UV = 23'd2800000;
  localparam logic [22:0] FFRS_RANGE3_MIN_UV = 23'd2425000;
  localparam logic [22:0] FFRS_RANGE3_MAX_UV = 23'd5600000;

  // protection events from the analog side
  typedef struct packed {
    logic overcurrent;
    logic short_circuit;
    logic input_undervoltage;
  } ffrs_event_type;

  // active output range handed to the regulation loop
  typedef struct packed {
    logic [1:0]  code;
    logic [22:0] min_uv;
    logic [22:0] max_uv;
  } ffrs_range_type;

endpackage

// file: ffrs_range_select.sv
/*
  Output range selector: picks the high-select or low-select range field
  by the synchronised voltage-select level and decodes it to limits.
  Assumes both fields and the select level are already on clk.
*/
`timescale 1ns/1ps
module ffrs_range_select (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // selection
  input  wire logic                    voltage_select,
  input  wire logic [1:0]              high_select_range_field,
  input  wire logic [1:0]              low_select_range_field,
  // result
  output ffrs_pkg::ffrs_range_type     active_range
);
  import ffrs_pkg::*;

  // both fields share one decode
  function automatic ffrs_range_type decode_range(input logic [1:0] code);
    ffrs_range_type r;
    r.code = code;
    case (code)
      2'h0: begin
        r.min_uv = FFRS_RANGE0_MIN_UV;
        r.max_uv = FFRS_RANGE0_MAX_UV;
      end
      2'h1: begin
        r.min_uv = FFRS_RANGE1_MIN_UV;
        r.max_uv = FFRS_RANGE1_MAX_UV;
      end
      2'h2: begin
        r.min_uv = FFRS_RANGE2_MIN_UV;
        r.max_uv = FFRS_RANGE2_MAX_UV;
      end
      default: begin
        r.min_uv = FFRS_RANGE3_MIN_UV;
        r.max_uv = FFRS_RANGE3_MAX_UV;
      end
    endcase
    return r;
  endfunction

  // registered so the loop sees clean limits; follows the pin live
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_range <= decode_range(FFRS_RANGE_LOW_RESET);
    end else if (voltage_select) begin
      active_range <= decode_range(high_select_range_field);
    end else begin
      active_range <= decode_range(low_select_range_field);
    end
  end

endmodule // ffrs_range_select

// file: ffrs_top.sv
/*
  Fault flag and output range select register bank behind a two-wire
  serial slave port (start, address, pointer, data, auto-increment).
  Assumes scl and sda are slow against clk (25 MHz, 400 kHz bus at most)
  and that protection events and pins come from outside the clock domain.
*/
//
// Behaviour
// - overcurrent sets sticky bit 7 of fault register
// - short circuit sets sticky bit 4
// - undervoltage while enabled sets sticky bit 1
// - select pin high uses high-select range field
// - select pin low uses low-select range field
// - range codes decode to four min/max voltage limit pairs
// - flags and range fields readable and writable
`timescale 1ns/1ps
module ffrs_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A // arbitrary bus address
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // serial port pins
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  // analog side
  input  ffrs_pkg::ffrs_event_type     protection_event,
  input  wire logic                    converter_enable,
  input  wire logic                    voltage_select_pin,
  // outputs to the regulation loop
  output ffrs_pkg::ffrs_event_type     event_flags,
  output ffrs_pkg::ffrs_range_type     active_range
);
  import ffrs_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } ffrs_state_type;

  // two-flop synchronisers; stage one feeds stage two only
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic       scl_d1_q;
  logic       sda_d1_q;

  logic                    overcurrent_event_flag_q;
  logic                    short_circuit_event_flag_q;
  logic                    input_undervoltage_event_flag_q;
  logic [1:0]              high_select_range_field_q;
  logic [1:0]              low_select_range_field_q;

  ffrs_state_type state_q;
  logic [3:0]     bit_cnt_q;
  logic [7:0]     rx_q;
  logic [7:0]     tx_q;
  logic [7:0]     ptr_q;
  logic           master_nack_q;
  logic           wr_stb_q;
  logic [7:0]     wr_addr_q;
  logic [7:0]     wr_data_q;

  logic [7:0]     rd_data;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;

  // register read mux; reserved bits and unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      FFRS_OFS_FLAGS: begin
        v[FFRS_BIT_OVERCURRENT]   = overcurrent_event_flag_q;
        v[FFRS_BIT_SHORT_CIRCUIT] = short_circuit_event_flag_q;
        v[FFRS_BIT_UNDERVOLTAGE]  = input_undervoltage_event_flag_q;
      end
      FFRS_OFS_RANGE_HIGH: v[1:0] = high_select_range_field_q;
      FFRS_OFS_RANGE_LOW:  v[1:0] = low_select_range_field_q;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  // byte about to be shifted out; a process, so flag changes are seen too
  always_comb begin
    rd_data = reg_read(ptr_q);
  end

  // synchronise pins and events before any logic looks at them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= 7'h60; // bus lines idle high, so no false edge after reset
      sync2_q <= 7'h60;
    end else begin
      sync1_q <= {scl_i, sda_i, protection_event, converter_enable, voltage_select_pin};
      sync2_q <= sync1_q;
    end
  end

  // delayed copies for edge detection, idle bus is high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  assign scl_s      = sync2_q[6];
  assign sda_s      = sync2_q[5];
  assign scl_rise   = scl_s & ~scl_d1_q;
  assign scl_fall   = ~scl_s & scl_d1_q;
  assign start_cond = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop_cond  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
  assign byte_done  = (bit_cnt_q == FFRS_BITS_PER_BYTE);

  // sample bits on rising scl; data bytes and master acknowledge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_q          <= 8'h00;
      master_nack_q <= 1'b1;
    end else if (scl_rise) begin
      if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WDATA) begin
        rx_q <= {rx_q[6:0], sda_s};
      end
      if (state_q == ST_RDATA_ACK) begin
        master_nack_q <= sda_s;
      end
    end
  end

  // protocol sequencer; drives sda only on falling scl so data is stable high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      sda_oe    <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_cond) begin
        state_q   <= ST_ADDR;   // repeated start keeps the pointer
        bit_cnt_q <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_rise && state_q != ST_IDLE && !byte_done) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (byte_done) begin
              if (rx_q[7:1] == SLAVE_ADDR) begin
                state_q <= ST_ADDR_ACK;
                sda_oe  <= 1'b1;
              end else begin
                state_q <= ST_IDLE;  // not ours, stay off the bus
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_q <= 4'h0;
            if (rx_q[0]) begin
              tx_q    <= rd_data;
              sda_oe  <= ~rd_data[7];
              ptr_q   <= ptr_q + 8'h01;
              state_q <= ST_RDATA;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (byte_done) begin
              ptr_q   <= rx_q;
              sda_oe  <= 1'b1;
              state_q <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              wr_stb_q  <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= rx_q;
              ptr_q     <= ptr_q + 8'h01;
              sda_oe    <= 1'b1;
              state_q   <= ST_WDATA_ACK;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            bit_cnt_q <= 4'h0;
            sda_oe    <= 1'b0;
            state_q   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (byte_done) begin
              sda_oe  <= 1'b0;     // release for master acknowledge
              state_q <= ST_RDATA_ACK;
            end else begin
              tx_q   <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[6];
            end
          end
          ST_RDATA_ACK: begin
            bit_cnt_q <= 4'h0;
            if (master_nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              tx_q    <= rd_data;
              sda_oe  <= ~rd_data[7];
              ptr_q   <= ptr_q + 8'h01;
              state_q <= ST_RDATA;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0; // open drain: only ever pulls low

  // sticky fault flags; an event in the clearing cycle still sets the flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {overcurrent_event_flag_q, short_circuit_event_flag_q,
       input_undervoltage_event_flag_q} <= FFRS_FLAGS_RESET;
    end else begin
      overcurrent_event_flag_q <= sync2_q[4]
        | ((wr_stb_q && wr_addr_q == FFRS_OFS_FLAGS)
           ? wr_data_q[FFRS_BIT_OVERCURRENT] : overcurrent_event_flag_q);
      short_circuit_event_flag_q <= sync2_q[3]
        | ((wr_stb_q && wr_addr_q == FFRS_OFS_FLAGS)
           ? wr_data_q[FFRS_BIT_SHORT_CIRCUIT] : short_circuit_event_flag_q);
      // undervoltage only counts once the converter is enabled
      input_undervoltage_event_flag_q <= (sync2_q[2] & sync2_q[1])
        | ((wr_stb_q && wr_addr_q == FFRS_OFS_FLAGS)
           ? wr_data_q[FFRS_BIT_UNDERVOLTAGE] : input_undervoltage_event_flag_q);
    end
  end

  // range fields; no lock while running, software must order its writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_select_range_field_q <= FFRS_RANGE_HIGH_RESET;
      low_select_range_field_q  <= FFRS_RANGE_LOW_RESET;
    end else if (wr_stb_q) begin
      if (wr_addr_q == FFRS_OFS_RANGE_HIGH) begin
        high_select_range_field_q <= wr_data_q[1:0];
      end
      if (wr_addr_q == FFRS_OFS_RANGE_LOW) begin
        low_select_range_field_q <= wr_data_q[1:0];
      end
    end
  end

  assign event_flags = '{overcurrent:        overcurrent_event_flag_q,
                         short_circuit:      short_circuit_event_flag_q,
                         input_undervoltage: input_undervoltage_event_flag_q};

  // active range by the synchronised select pin
  ffrs_range_select u_range_select (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .voltage_select          (sync2_q[0]),
    .high_select_range_field (high_select_range_field_q),
    .low_select_range_field  (low_select_range_field_q),
    .active_range            (active_range)
  );

endmodule // ffrs_top

// file: ffrs_monitor.sv
/* ffrs_monitor: port-level assertions for the fault flag and range bank.
   Assumes it is bound into ffrs_top and runs on its clk domain. */
`timescale 1ns/1ps
module ffrs_monitor (
  // clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // serial pins
  input wire logic               scl_i,
  input wire logic               sda_oe,
  // analog side and results
  input wire ffrs_pkg::ffrs_event_type protection_event,
  input wire logic               converter_enable,
  input wire logic               voltage_select_pin,
  input wire ffrs_pkg::ffrs_event_type event_flags,
  input wire ffrs_pkg::ffrs_range_type active_range
);
  import ffrs_pkg::*;
  localparam logic [22:0] MN [4] = '{FFRS_RANGE0_MIN_UV, FFRS_RANGE1_MIN_UV,
                                     FFRS_RANGE2_MIN_UV, FFRS_RANGE3_MIN_UV};
  localparam logic [22:0] MX [4] = '{FFRS_RANGE0_MAX_UV, FFRS_RANGE1_MAX_UV,
                                     FFRS_RANGE2_MAX_UV, FFRS_RANGE3_MAX_UV};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // reset checks override the default disable, they watch reset itself
  a_reset_flags: assert property (disable iff (1'b0)
    !reset_n |=> event_flags == 3'h0) else $error("flags not cleared");
  a_reset_range: assert property (disable iff (1'b0)
    !reset_n ##1 !reset_n |=> active_range.code == 2'h1) else $error("range reset");
  // events are synchronised, so allow a few cycles to land
  a_oc_sets: assert property (protection_event.overcurrent [*2]
    |-> ##[1:4] event_flags.overcurrent) else $error("overcurrent lost");
  a_sc_sets: assert property (protection_event.short_circuit [*2]
    |-> ##[1:4] event_flags.short_circuit) else $error("short lost");
  a_uv_sets: assert property ((protection_event.input_undervoltage
    && converter_enable) [*4] |-> ##[0:4] event_flags.input_undervoltage)
    else $error("undervoltage lost");
  a_range_decode: assert property (active_range.min_uv == MN[active_range.code]
    && active_range.max_uv == MX[active_range.code]) else $error("bad decode");
  // no bus edge and a steady pin leave nothing that may move the range
  a_range_hold: assert property ((scl_i && $stable(voltage_select_pin)) [*8]
    |-> $stable(active_range)) else $error("range moved");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda changed while scl high");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("driven bit too short");
endmodule // ffrs_monitor

// file: ffrs_host.sv
/* ffrs_host: two-wire bus host model that reaches the register bank.
   Assumes a pulled-up data line whose wired level arrives on sda_in. */
`timescale 1ns/1ps
module ffrs_host (
  // clock
  input wire logic clk,
  // bus pins
  input wire logic sda_in,
  output logic     scl,
  output logic     sda_low
);
  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // a quarter bit of five clk keeps scl far slower than clk/10
  task automatic q;
    repeat (5) @(negedge clk);
  endtask
  task automatic wbit(input logic b);
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic rbit(output logic b);
    sda_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    b = sda_in;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic start;
    sda_low = 1'b0;
    scl = 1'b1;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask
  // most significant bit first, then the ninth bit for acknowledge
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(v[i]);
    rbit(b);
    ack = !b;
  endtask
  task automatic rbyte(output logic [7:0] v, input logic nack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      rbit(b);
      v[i] = b;
    end
    wbit(nack);
  endtask
endmodule // ffrs_host

// file: ffrs_top_tb.sv
/* ffrs_top_tb: register bank driven through the two-wire host model.
   Assumes ffrs_top with its default bus address and a 25 MHz clk. */
`timescale 1ns/1ps
module ffrs_top_tb;
  import ffrs_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [22:0] MN [4] = '{FFRS_RANGE0_MIN_UV, FFRS_RANGE1_MIN_UV,
                                     FFRS_RANGE2_MIN_UV, FFRS_RANGE3_MIN_UV};
  localparam logic [22:0] MX [4] = '{FFRS_RANGE0_MAX_UV, FFRS_RANGE1_MAX_UV,
                                     FFRS_RANGE2_MAX_UV, FFRS_RANGE3_MAX_UV};
  logic           clk, reset_n, scl_i, sda_low, sda_o, sda_oe, a;
  logic           converter_enable, voltage_select_pin;
  ffrs_event_type protection_event, event_flags;
  ffrs_range_type active_range;
  int             errors, compares;
  // pulled-up wired bus: low when either side pulls
  wire            sda_i = !(sda_low || (sda_oe && !sda_o));
  ffrs_top dut (.clk, .reset_n, .scl_i, .sda_i, .sda_o, .sda_oe, .protection_event,
    .converter_enable, .voltage_select_pin, .event_flags, .active_range);
  ffrs_host host (.clk, .sda_in(sda_i), .scl(scl_i), .sda_low);
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic fail(input string m);
    errors++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic chk1(input logic g, e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask
  task automatic chk8(input logic [7:0] g, e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_rng(input logic [1:0] c);
    compares++;
    if (active_range !== {c, MN[c], MX[c]}) fail("active range");
  endtask
  task automatic wr(input logic [7:0] o, v);
    logic a1, a2, a3;
    host.start;
    host.wbyte({ADDR, 1'b0}, a1);
    host.wbyte(o, a2);
    host.wbyte(v, a3);
    host.stop;
    chk1(a1 & a2 & a3, 1'b1, "write not acked");
  endtask
  // two data bytes in one frame, pointer steps on by itself
  task automatic wr2(input logic [7:0] o, v0, v1);
    logic a1, a2, a3, a4;
    host.start;
    host.wbyte({ADDR, 1'b0}, a1);
    host.wbyte(o, a2);
    host.wbyte(v0, a3);
    host.wbyte(v1, a4);
    host.stop;
    chk1(a1 & a2 & a3 & a4, 1'b1, "burst write not acked");
  endtask
  // pointer write, repeated start, single byte ended by a nack
  task automatic rchk(input logic [7:0] o, e, input string m);
    logic a1, a2, a3;
    logic [7:0] v;
    host.start;
    host.wbyte({ADDR, 1'b0}, a1);
    host.wbyte(o, a2);
    host.start;
    host.wbyte({ADDR, 1'b1}, a3);
    host.rbyte(v, 1'b1);
    host.stop;
    chk1(a1 & a2 & a3, 1'b1, "read not acked");
    chk8(v, e, m);
  endtask
  // two bytes in one frame: master acknowledge first, then nack
  task automatic rchk2(input logic [7:0] o, e0, e1, input string m);
    logic a1, a2, a3;
    logic [7:0] v0, v1;
    host.start;
    host.wbyte({ADDR, 1'b0}, a1);
    host.wbyte(o, a2);
    host.start;
    host.wbyte({ADDR, 1'b1}, a3);
    host.rbyte(v0, 1'b0);
    host.rbyte(v1, 1'b1);
    host.stop;
    chk1(a1 & a2 & a3, 1'b1, "burst read not acked");
    chk8(v0, e0, m);
    chk8(v1, e1, m);
  endtask
  task automatic pulse(input logic [2:0] p);
    protection_event = p;
    repeat (3) @(negedge clk);
    protection_event = 3'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic final_report;
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // the full sequence needs about 18k clk
  initial begin
    repeat (80000) @(posedge clk);
    fail("timeout");
    final_report;
  end
  initial begin
    errors = 0;
    compares = 0;
    reset_n = 1'b0;
    protection_event = 3'h0;
    converter_enable = 1'b0;
    voltage_select_pin = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk_rng(2'h1);
    chk8({5'h00, event_flags}, 8'h00, "flag outputs after reset");
    rchk(8'h18, 8'h00, "flags after reset");
    rchk(8'h1C, 8'h02, "high field after reset");
    rchk(8'h1D, 8'h01, "low field after reset");
    voltage_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_rng(2'h2);
    // every code, with reserved bits written as ones
    for (int c = 0; c < 4; c++) begin
      wr(8'h1C, {6'h3F, 2'(c)});
      repeat (4) @(negedge clk);
      chk_rng(2'(c));
      rchk(8'h1C, {6'h00, 2'(c)}, "high field");
    end
    voltage_select_pin = 1'b0;
    for (int c = 3; c >= 0; c--) begin
      wr(8'h1D, {6'h00, 2'(c)});
      repeat (4) @(negedge clk);
      chk_rng(2'(c));
    end
    voltage_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_rng(2'h3);
    pulse(3'b100);
    rchk(8'h18, 8'h80, "overcurrent flag");
    pulse(3'b010);
    rchk(8'h18, 8'h90, "short flag");
    pulse(3'b001);
    rchk(8'h18, 8'h90, "undervoltage while off");
    // converter enabled only once both ranges are set
    converter_enable = 1'b1;
    repeat (4) @(negedge clk);
    pulse(3'b001);
    rchk(8'h18, 8'h92, "undervoltage flag");
    wr(8'h18, 8'h00);
    rchk(8'h18, 8'h00, "flags cleared");
    wr(8'h18, 8'hFF);
    rchk(8'h18, 8'h92, "flags set by host");
    chk8({5'h00, event_flags}, 8'h07, "flag outputs");
    rchk(8'h20, 8'h00, "unmapped offset");
    // banks change only with the converter stopped
    converter_enable = 1'b0;
    wr2(8'h1C, 8'h01, 8'h03);
    rchk2(8'h1C, 8'h01, 8'h03, "burst ranges");
    chk_rng(2'h1);
    host.start;
    host.wbyte({~ADDR, 1'b0}, a);
    host.stop;
    chk1(a, 1'b0, "foreign address acked");
    final_report;
  end
endmodule // ffrs_top_tb
bind ffrs_top ffrs_monitor mon (.clk, .reset_n, .scl_i, .sda_oe, .protection_event,
  .converter_enable, .voltage_select_pin, .event_flags, .active_range);
